// file: include/itp_consts.svh
// Offsets, field positions, reset values and timing figures of the transmit packer
`ifndef ITP_CONSTS_SVH
`define ITP_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ITP_ADDR_CTL      12'h020
`define ITP_ADDR_HQ1      12'h024
`define ITP_ADDR_HQ2      12'h028
`define ITP_ADDR_STAT     12'h03C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ITP_CTL_RESET     32'h00000001
`define ITP_HQ1_RESET     32'h00000000
`define ITP_HQ2_RESET     32'h00000000

// ----------------------------------------------------------------
// Packing control fields
// ----------------------------------------------------------------
`define ITP_CTL_AUDIO     30
`define ITP_CTL_CLK_HI    29
`define ITP_CTL_CLK_LO    28
`define ITP_CTL_TRANSPORT_DELAY_HI  27
`define ITP_CTL_TRANSPORT_DELAY_LO  16
`define ITP_CTL_MAX_BLOCKS_PER_PAYLOAD_HI  15
`define ITP_CTL_MAX_BLOCKS_PER_PAYLOAD_LO  8
`define ITP_CTL_EXTSTAMP  7
`define ITP_CTL_SYTD_HI   6
`define ITP_CTL_SYTD_LO   5
`define ITP_CTL_EN        4
`define ITP_CTL_PM_HI     3
`define ITP_CTL_PM_LO     2
`define ITP_CTL_ENFS      1
`define ITP_CTL_RST       0

// ----------------------------------------------------------------
// Header quadlet fields
// ----------------------------------------------------------------
`define ITP_HQ1_DBS_HI    23
`define ITP_HQ1_DBS_LO    16
`define ITP_HQ1_FN_HI     15
`define ITP_HQ1_FN_LO     14
`define ITP_HQ1_QPC_HI    13
`define ITP_HQ1_QPC_LO    11
`define ITP_HQ1_SPH       10
`define ITP_HQ2_SYT_HI    15

// ----------------------------------------------------------------
// Timing and stamping figures
// ----------------------------------------------------------------
`define ITP_PCLK_KHZ      100000
`define ITP_AVCLK1_KHZ    24576
`define ITP_AVCLK2_KHZ    12288
`define ITP_AVCLK3_KHZ    6144
`define ITP_NCO_SCALE     65536
`define ITP_OFFSET_WRAP   13'h0C00
`define ITP_SYT_NONE      16'hFFFF
`define ITP_AUDIO_EXTRA   4'h2
`define ITP_SYTD_CODE01   4'h2
`define ITP_SYTD_CODE00   4'h3
`define ITP_SYTD_CODE10   4'h4
`define ITP_DBS_ZERO      9'h100

`endif

// file: include/itp_pkg.sv
// Types shared by the transmit packer files
package itp_pkg;

  typedef enum logic [2:0] {
    ITP_IDLE = 3'b000,
    ITP_HDR1 = 3'b001,
    ITP_HDR2 = 3'b010,
    ITP_WAIT = 3'b011,
    ITP_LOAD = 3'b100,
    ITP_DATA = 3'b101
  } itp_state_t;

  typedef enum logic [1:0] {
    ITP_PM_VAR  = 2'b00,
    ITP_PM_FIX  = 2'b01,
    ITP_PM_MPEG = 2'b10,
    ITP_PM_CIP  = 2'b11
  } itp_pm_t;

endpackage

// file: logic/itp_qram.sv
// Quadlet store of the transmit packer with registered read data
`timescale 1ns/1ps

module itp_qram #(
  parameter int W  = 32,
  parameter int AW = 10
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // itp_qram

// file: logic/itp_packer.sv
// Isochronous transmit packer: AV port intake, CIP headers, stamps, bus packets
// Function
// - Audio mode holds stamp for empty packet
// - Frame sync makes stamp from cycle timer
// - Audio mode adds two cycles to delay
// - Clock select: input, 24.576, 12.288, 6.144
// - Only enabled transmitter port drives clock
// - Transport delay added to cycle timer fields
// - Payload blocks never exceed maximum block count
// - External stamp replaces internal; needs SPH
// - Sync delay codes 2, 3, 4 cycles
// - Enable sends every cycle; disable finishes packet
// - Packing mode: variable, fixed, MPEG-2, headers
// - SYT insertion replaces low sixteen bits
// - Reset flushes FIFO, stops at once
// - Block size zero means 256 quadlets
// - Fraction code gives 1, 2, 4, 8
// - Dummy quadlets padded before splitting blocks
// - SPH inserts 25-bit stamp per packet
// - Second header register sent every packet
// - Cycle timer: count high, offset low
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "itp_consts.svh"

module itp_packer
  import itp_pkg::*;
#(
  parameter int FIFO_AW = 10
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic [24:0] cycle_timer,
  input  wire logic        cycle_start,
  input  wire logic        av_port_is_transmitter,
  input  wire logic        av_port_clock_pin_in,
  output logic             av_port_clock_pin_out,
  output logic             av_port_clock_pin_oe_n,
  input  wire logic [7:0]  av_data_in,
  input  wire logic        packet_sync_strobe,
  input  wire logic        data_valid_strobe,
  input  wire logic        frame_sync_input,
  output logic             pkt_valid,
  output logic      [31:0] pkt_data,
  output logic             pkt_first,
  output logic             pkt_last,
  input  wire logic        pkt_ready,
  output logic             tx_active
);

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  function automatic logic [3:0] fn_blocks(input logic [1:0] code);
    fn_blocks = 4'h1 << code;
  endfunction

  function automatic logic [3:0] syt_cycles(input logic [1:0] code);
    unique case (code)
      2'b01:   syt_cycles = `ITP_SYTD_CODE01;
      2'b10:   syt_cycles = `ITP_SYTD_CODE10;
      default: syt_cycles = `ITP_SYTD_CODE00;
    endcase
  endfunction

  localparam logic [15:0] NCO_INC1 = 16'((`ITP_AVCLK1_KHZ * `ITP_NCO_SCALE) / `ITP_PCLK_KHZ);
  localparam logic [15:0] NCO_INC2 = 16'((`ITP_AVCLK2_KHZ * `ITP_NCO_SCALE) / `ITP_PCLK_KHZ);
  localparam logic [15:0] NCO_INC3 = 16'((`ITP_AVCLK3_KHZ * `ITP_NCO_SCALE) / `ITP_PCLK_KHZ);
  localparam logic [FIFO_AW:0] FIFO_DEPTH = (FIFO_AW+1)'(1 << FIFO_AW);

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  logic [31:0] ctl_r;
  logic [31:0] hq1_r;
  logic [31:0] hq2_r;
  logic [31:0] prdata_r;
  itp_state_t  state_r;
  logic [7:0]  dbc_r;
  logic        syt_pend_r;
  logic [FIFO_AW:0] fifo_cnt_r;

  wire        hit_ctl  = paddr == `ITP_ADDR_CTL;
  wire        hit_hq1  = paddr == `ITP_ADDR_HQ1;
  wire        hit_hq2  = paddr == `ITP_ADDR_HQ2;
  wire        hit_stat = paddr == `ITP_ADDR_STAT;
  wire        hit_any  = hit_ctl | hit_hq1 | hit_hq2 | hit_stat;
  wire        apb_wr   = psel & penable & pwrite;
  wire [31:0] stat_val = {dbc_r, state_r, syt_pend_r, (20-FIFO_AW-1)'(0), fifo_cnt_r};
  wire [31:0] rd_mux   = hit_ctl  ? ctl_r :
                         hit_hq1  ? hq1_r :
                         hit_hq2  ? hq2_r :
                         hit_stat ? stat_val : 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r    <= `ITP_CTL_RESET;
      hq1_r    <= `ITP_HQ1_RESET;
      hq2_r    <= `ITP_HQ2_RESET;
      prdata_r <= 32'h00000000;
    end else begin
      if (apb_wr && hit_ctl) ctl_r <= pwdata;
      if (apb_wr && hit_hq1) hq1_r <= pwdata;
      if (apb_wr && hit_hq2) hq2_r <= pwdata;
      if (psel && !penable && !pwrite) prdata_r <= rd_mux;
    end
  end

  wire        audio    = ctl_r[`ITP_CTL_AUDIO];
  wire [1:0]  clk_sel  = ctl_r[`ITP_CTL_CLK_HI:`ITP_CTL_CLK_LO];
  wire [11:0] transport_delay    = ctl_r[`ITP_CTL_TRANSPORT_DELAY_HI:`ITP_CTL_TRANSPORT_DELAY_LO];
  wire [7:0]  max_blocks_per_payload    = ctl_r[`ITP_CTL_MAX_BLOCKS_PER_PAYLOAD_HI:`ITP_CTL_MAX_BLOCKS_PER_PAYLOAD_LO];
  wire        ext_stmp = ctl_r[`ITP_CTL_EXTSTAMP];
  wire [1:0]  sytd     = ctl_r[`ITP_CTL_SYTD_HI:`ITP_CTL_SYTD_LO];
  wire        tx_en    = ctl_r[`ITP_CTL_EN];
  wire [1:0]  pm       = ctl_r[`ITP_CTL_PM_HI:`ITP_CTL_PM_LO];
  wire        syt_insert_enable    = ctl_r[`ITP_CTL_ENFS];
  wire        tx_rst   = ctl_r[`ITP_CTL_RST];
  wire [7:0]  dbs      = hq1_r[`ITP_HQ1_DBS_HI:`ITP_HQ1_DBS_LO];
  wire [1:0]  fn       = hq1_r[`ITP_HQ1_FN_HI:`ITP_HQ1_FN_LO];
  wire [2:0]  qpc      = hq1_r[`ITP_HQ1_QPC_HI:`ITP_HQ1_QPC_LO];
  wire        sph      = hq1_r[`ITP_HQ1_SPH];

  wire [8:0]  dbs_eff   = (dbs == 8'h00) ? `ITP_DBS_ZERO : {1'b0, dbs};
  wire [3:0]  nfn       = fn_blocks(fn);
  wire [12:0] sp_target = {4'h0, dbs_eff} * {9'h000, nfn};
  wire [12:0] app_tgt   = sp_target - {10'h000, qpc};

  // ----------------------------------------------------------------
  // Pin synchronisers and AV clock
  // ----------------------------------------------------------------
  logic [11:0] sync1_r;
  logic [11:0] sync2_r;
  logic        avlvl_q_r;
  logic        fs_q_r;
  logic [15:0] nco_r;
  logic        clk_out_r;

  wire [11:0] pins_raw = {av_port_clock_pin_in, packet_sync_strobe, data_valid_strobe, frame_sync_input,
                          av_data_in};
  wire        ck_s     = sync2_r[11];
  wire        psync_s  = sync2_r[10];
  wire        dval_s   = sync2_r[9];
  wire        fs_s     = sync2_r[8];
  wire [7:0]  data_s   = sync2_r[7:0];
  wire [15:0] nco_inc  = (clk_sel == 2'b01) ? NCO_INC1 :
                         (clk_sel == 2'b10) ? NCO_INC2 :
                         (clk_sel == 2'b11) ? NCO_INC3 : 16'h0000;
  wire        av_lvl   = (clk_sel == 2'b00) ? ck_s : nco_r[15];
  wire        av_edge  = av_lvl & ~avlvl_q_r;
  wire        fs_edge  = fs_s & ~fs_q_r;

  assign av_port_clock_pin_out  = clk_out_r;
  assign av_port_clock_pin_oe_n = ~((clk_sel != 2'b00) & av_port_is_transmitter & tx_en);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r   <= 12'h000;
      sync2_r   <= 12'h000;
      avlvl_q_r <= 1'b0;
      fs_q_r    <= 1'b0;
      nco_r     <= 16'h0000;
      clk_out_r <= 1'b0;
    end else begin
      sync1_r   <= pins_raw;
      sync2_r   <= sync1_r;
      avlvl_q_r <= av_lvl;
      fs_q_r    <= fs_s;
      nco_r     <= nco_r + nco_inc;
      clk_out_r <= nco_r[15];
    end
  end

  // ----------------------------------------------------------------
  // Stamps from the cycle timer
  // ----------------------------------------------------------------
  wire [12:0] cyc_count = cycle_timer[24:12];
  wire [11:0] cyc_off   = cycle_timer[11:0];
  wire [12:0] off_sum   = {1'b0, cyc_off} + {1'b0, transport_delay[3:0], 8'h00};
  wire        off_wrap  = off_sum >= `ITP_OFFSET_WRAP;
  wire [12:0] off_adj   = off_wrap ? (off_sum - `ITP_OFFSET_WRAP) : off_sum;
  wire [12:0] cnt_sum   = cyc_count + {5'h00, transport_delay[11:4]} + {12'h000, off_wrap};
  wire [24:0] tstamp    = {cnt_sum, off_adj[11:0]};
  wire [3:0]  syt_dly   = syt_cycles(sytd) + (audio ? `ITP_AUDIO_EXTRA : 4'h0);
  wire [15:0] syt_new   = {cycle_timer[15:12] + syt_dly, cyc_off};
  logic [15:0] syt_r;

  // ----------------------------------------------------------------
  // Intake: bytes to quadlets, stamp and pad quadlets
  // ----------------------------------------------------------------
  logic [1:0]       byte_idx_r;
  logic [23:0]      qbuf_r;
  logic [12:0]      sp_cnt_r;
  logic [2:0]       pad_left_r;
  logic [8:0]       blkq_r;
  logic [11:0]      blocks_r;
  logic [FIFO_AW-1:0] wr_ptr_r;
  logic [FIFO_AW-1:0] rd_ptr_r;
  logic [31:0]      mem_rdata;

  wire        take_byte = av_edge & dval_s & tx_en & ~tx_rst;
  wire        sp_start  = take_byte & psync_s;
  wire        stamp_wr  = sp_start & sph & ~ext_stmp;
  wire        quad_wr   = take_byte & ~psync_s & (byte_idx_r == 2'b11);
  wire        pad_wr    = ~stamp_wr & ~quad_wr & (pad_left_r != 3'h0);
  wire        fifo_full = fifo_cnt_r == FIFO_DEPTH;
  wire        wr_en     = (stamp_wr | quad_wr | pad_wr) & ~fifo_full & ~tx_rst;
  wire [31:0] wr_data   = stamp_wr ? {7'h00, tstamp} :
                          quad_wr  ? {qbuf_r, data_s} : 32'h00000000;
  wire [12:0] sp_cnt_inc = sp_cnt_r + 13'h0001;
  wire        blk_done  = wr_en & (blkq_r + 9'h001 == dbs_eff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_idx_r <= 2'b00;
      qbuf_r     <= 24'h000000;
      sp_cnt_r   <= 13'h0000;
      pad_left_r <= 3'h0;
      blkq_r     <= 9'h000;
      wr_ptr_r   <= '0;
    end else if (tx_rst) begin
      byte_idx_r <= 2'b00;
      sp_cnt_r   <= 13'h0000;
      pad_left_r <= 3'h0;
      blkq_r     <= 9'h000;
      wr_ptr_r   <= '0;
    end else begin
      if (take_byte) begin
        byte_idx_r <= psync_s ? 2'b01 : byte_idx_r + 2'b01;
        unique case (psync_s ? 2'b00 : byte_idx_r)
          2'b00:   qbuf_r[23:16] <= data_s;
          2'b01:   qbuf_r[15:8]  <= data_s;
          2'b10:   qbuf_r[7:0]   <= data_s;
          2'b11:   qbuf_r        <= qbuf_r;
        endcase
      end
      if (sp_start) begin
        sp_cnt_r <= stamp_wr ? 13'h0001 : 13'h0000;
      end else if (quad_wr) begin
        sp_cnt_r <= sp_cnt_inc;
        if (sp_cnt_inc == app_tgt) pad_left_r <= qpc;
      end else if (pad_wr) begin
        pad_left_r <= pad_left_r - 3'h1;
      end
      if (wr_en) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
        blkq_r   <= blk_done ? 9'h000 : blkq_r + 9'h001;
      end
    end
  end

  itp_qram #(
    .W  (32),
    .AW (FIFO_AW)
  ) u_qram (
    .clk   (pclk),
    .we    (wr_en),
    .waddr (wr_ptr_r),
    .wdata (wr_data),
    .raddr (rd_ptr_r),
    .rdata (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Bus packet formation
  // ----------------------------------------------------------------
  logic [7:0]  n_blk_r;
  logic [16:0] quads_left_r;
  logic [31:0] out_r;
  logic [31:0] hdr2_r;

  wire [7:0]  cap      = (blocks_r > {4'h0, max_blocks_per_payload}) ? max_blocks_per_payload : blocks_r[7:0];
  wire [7:0]  fn_mask  = ~(8'(nfn) - 8'h01);
  wire [7:0]  n_blk    = (pm == ITP_PM_VAR)  ? cap :
                         (pm == ITP_PM_FIX)  ? ((blocks_r >= {4'h0, max_blocks_per_payload}) ? max_blocks_per_payload : 8'h00) :
                         (pm == ITP_PM_MPEG) ? (cap & fn_mask) : 8'h00;
  wire        start    = cycle_start & (state_r == ITP_IDLE) & tx_en & ~tx_rst;
  wire        syt_use  = syt_insert_enable & syt_pend_r & ~(audio & (n_blk == 8'h00));
  wire [15:0] syt_fld  = syt_use ? syt_r : `ITP_SYT_NONE;
  wire [31:0] hdr1     = {hq1_r[31:8], dbc_r};
  wire [31:0] hdr2     = syt_insert_enable ? {hq2_r[31:16], syt_fld} : hq2_r;
  wire        beat     = pkt_valid & pkt_ready;
  wire        rd_en    = (state_r == ITP_DATA) & pkt_ready;
  wire [16:0] n_quads  = {9'h000, n_blk} * {8'h00, dbs_eff};

  assign pkt_valid = (state_r == ITP_HDR1) | (state_r == ITP_HDR2) | (state_r == ITP_DATA);
  assign pkt_data  = out_r;
  assign pkt_first = state_r == ITP_HDR1;
  assign pkt_last  = ((state_r == ITP_HDR2) & (quads_left_r == 17'h00000)) |
                     ((state_r == ITP_DATA) & (quads_left_r == 17'h00001));
  assign tx_active = state_r != ITP_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= ITP_IDLE;
      n_blk_r      <= 8'h00;
      quads_left_r <= 17'h00000;
      out_r        <= 32'h00000000;
      hdr2_r       <= 32'h00000000;
      dbc_r        <= 8'h00;
      rd_ptr_r     <= '0;
    end else if (tx_rst) begin
      state_r      <= ITP_IDLE;
      quads_left_r <= 17'h00000;
      rd_ptr_r     <= '0;
    end else begin
      if (rd_en) rd_ptr_r <= rd_ptr_r + 1'b1;
      unique case (state_r)
        ITP_IDLE: begin
          if (start) begin
            state_r      <= ITP_HDR1;
            n_blk_r      <= n_blk;
            quads_left_r <= n_quads;
            out_r        <= hdr1;
            hdr2_r       <= hdr2;
            dbc_r        <= dbc_r + n_blk;
          end
        end
        ITP_HDR1: begin
          if (pkt_ready) begin
            state_r <= ITP_HDR2;
            out_r   <= hdr2_r;
          end
        end
        ITP_HDR2: begin
          if (pkt_ready) state_r <= (quads_left_r == 17'h00000) ? ITP_IDLE : ITP_WAIT;
        end
        ITP_WAIT: state_r <= ITP_LOAD;
        ITP_LOAD: begin
          out_r   <= mem_rdata;
          state_r <= ITP_DATA;
        end
        ITP_DATA: begin
          if (pkt_ready) begin
            quads_left_r <= quads_left_r - 17'h00001;
            state_r      <= (quads_left_r == 17'h00001) ? ITP_IDLE : ITP_WAIT;
          end
        end
        default: state_r <= ITP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // FIFO level, block count and pending SYT
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_cnt_r <= '0;
      blocks_r   <= 12'h000;
      syt_pend_r <= 1'b0;
      syt_r      <= 16'h0000;
    end else if (tx_rst) begin
      fifo_cnt_r <= '0;
      blocks_r   <= 12'h000;
      syt_pend_r <= 1'b0;
    end else begin
      fifo_cnt_r <= fifo_cnt_r + (FIFO_AW+1)'(wr_en) - (FIFO_AW+1)'(rd_en);
      blocks_r   <= blocks_r + {11'h000, blk_done} - (start ? {4'h0, n_blk} : 12'h000);
      if (fs_edge) begin
        syt_pend_r <= 1'b1;
        syt_r      <= syt_new;
      end else if (start && syt_use) begin
        syt_pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    start ##1 (state_r == ITP_HDR1);
  endsequence

  property p_reset_flush;
    tx_rst |=> (fifo_cnt_r == '0) && (state_r == ITP_IDLE) && !pkt_valid;
  endproperty
  a_reset_flush: assert property (p_reset_flush) else $error("reset did not flush");

  property p_max_blocks;
    start |=> (n_blk_r <= $past(max_blocks_per_payload));
  endproperty
  a_max_blocks: assert property (p_max_blocks) else $error("too many blocks");

  property p_header_order;
    s_start |-> (pkt_first && pkt_data == $past(hdr1)) ##1 (state_r == ITP_HDR2 || !$past(pkt_ready));
  endproperty
  a_header_order: assert property (p_header_order) else $error("header order wrong");

  property p_syt_off;
    start && !syt_insert_enable |=> hdr2_r == $past(hq2_r);
  endproperty
  a_syt_off: assert property (p_syt_off) else $error("header two altered");

  property p_audio_hold;
    start && audio && syt_insert_enable && n_blk == 8'h00 && syt_pend_r && !fs_edge |=> syt_pend_r && hdr2_r[15:0] == 16'hFFFF;
  endproperty
  a_audio_hold: assert property (p_audio_hold) else $error("stamp lost on empty packet");

  property p_dbs_zero;
    dbs == 8'h00 |-> dbs_eff == 9'h100 && sp_target == {1'b0, nfn, 8'h00};
  endproperty
  a_dbs_zero: assert property (p_dbs_zero) else $error("block size zero wrong");

  property p_clk_drive;
    !av_port_clock_pin_oe_n |-> clk_sel != 2'b00 && av_port_is_transmitter && tx_en;
  endproperty
  a_clk_drive: assert property (p_clk_drive) else $error("clock driven when not allowed");

  property p_frame_stamp;
    fs_edge && !tx_rst |=> syt_pend_r && syt_r == $past(syt_new);
  endproperty
  a_frame_stamp: assert property (p_frame_stamp) else $error("frame sync stamp missing");

  property p_cip_only;
    start && pm == 2'b11 |=> quads_left_r == 17'h00000 ##1 state_r != ITP_WAIT ##1 state_r != ITP_WAIT;
  endproperty
  a_cip_only: assert property (p_cip_only) else $error("data sent in header mode");

endmodule // itp_packer

// file: tb/itp_codec_model.sv
// Behavioural application codec on the byte-wide AV port
`timescale 1ns/1ps

module itp_codec_model (
  input  wire logic        send,
  input  wire logic [31:0] word,
  output logic             av_clk,
  output logic [7:0]       av_data,
  output logic             av_sync,
  output logic             av_valid,
  output logic             busy
);
  initial begin
    {av_clk, av_sync, av_valid, busy} = 4'h0;
    av_data = 8'h00;
  end
  // One source packet, bytes change on the falling AV clock edge; clock idle between frames
  always @(posedge send) begin
    busy = 1'b1;
    for (int i = 0; i < 4; i++) begin
      #80 av_clk = 1'b0;
      av_data = word[31-8*i -: 8];
      av_sync = (i == 0);
      av_valid = 1'b1;
      #80 av_clk = 1'b1;
    end
    #80 av_clk = 1'b0;
    {av_sync, av_valid} = 2'b00;
    av_data = ~av_data;
    #160 busy = 1'b0;
  end
endmodule // itp_codec_model

// file: tb/tb_top.sv
// Self-checking testbench of the transmit packer
`timescale 1ns/1ps
`include "itp_consts.svh"

module tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        cs = 1'b0, is_tx = 1'b1, fs_in = 1'b0, send = 1'b0, e, rdy = 1'b1, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, word = 32'h0, prdata, pd;
  logic [24:0] ct = 25'h0015ABC;
  logic        pready, pslverr, ck_o, oe_n, pv, pf, pl, act, avc, sy, vl, busy;
  logic [7:0]  avd;
  logic [31:0] pk [0:7];
  int          np, fails = 0, checked = 0;

  always #5 pclk = ~pclk;
  always @(posedge pclk) rdy <= !slow || !rdy;

  itp_packer i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cycle_timer(ct), .cycle_start(cs), .av_port_is_transmitter(is_tx), .av_port_clock_pin_in(avc),
    .av_port_clock_pin_out(ck_o), .av_port_clock_pin_oe_n(oe_n), .av_data_in(avd),
    .packet_sync_strobe(sy), .data_valid_strobe(vl), .frame_sync_input(fs_in), .pkt_valid(pv),
    .pkt_data(pd), .pkt_first(pf), .pkt_last(pl), .pkt_ready(rdy), .tx_active(act));
  itp_codec_model i_codec (.send(send), .word(word), .av_clk(avc), .av_data(avd), .av_sync(sy),
    .av_valid(vl), .busy(busy));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  function automatic logic [31:0] ctl(input logic au, input logic [1:0] ck, input logic [1:0] sd,
                                      input logic en, input logic [1:0] pm, input logic fs, input logic rs);
    return {1'b0, au, ck, 12'h000, 8'h01, 1'b0, sd, en, pm, fs, rs};
  endfunction
  task automatic cycle();
    logic last;
    last = 1'b0;
    np = 0;
    @(posedge pclk);
    cs <= 1'b1;
    @(posedge pclk);
    cs <= 1'b0;
    while (!last) begin
      @(posedge pclk);
      if (pv === 1'b1 && rdy === 1'b1) begin
        chk(pf, np == 0);
        pk[np[2:0]] = pd;
        np++;
        last = (pl === 1'b1);
      end
    end
  endtask
  task automatic frame();
    @(posedge pclk);
    fs_in <= 1'b1;
    repeat (6) @(posedge pclk);
    fs_in <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic send_word(input logic [31:0] w);
    @(posedge pclk);
    word <= w;
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    @(posedge pclk);
    while (busy === 1'b1) @(posedge pclk);
    repeat (8) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, `ITP_ADDR_CTL, 32'h0);
    chk(rd, `ITP_CTL_RESET);
    apb(1'b0, `ITP_ADDR_HQ1, 32'h0);
    chk(rd, `ITP_HQ1_RESET);
    apb(1'b0, `ITP_ADDR_HQ2, 32'h0);
    chk(rd, `ITP_HQ2_RESET);
    apb(1'b0, 12'h100, 32'h0);
    chk({rd[31:1], e}, 32'h00000001);
    apb(1'b1, `ITP_ADDR_HQ2, 32'h02123456);
    apb(1'b0, `ITP_ADDR_HQ2, 32'h0);
    chk(rd, 32'h02123456);
  endtask
  task automatic t_clk();
    int n;
    logic p;
    for (int k = 1; k < 4; k++) begin
      apb(1'b1, `ITP_ADDR_CTL, ctl(1'b0, k[1:0], 2'b00, 1'b1, 2'b11, 1'b0, 1'b0));
      n = 0;
      p = ck_o;
      repeat (200) begin
        @(posedge pclk);
        n += (ck_o === 1'b1 && p === 1'b0);
        p = ck_o;
      end
      chk(32'(n >= (49 >> (k - 1)) - 2 && n <= (49 >> (k - 1)) + 2), 32'h1);
      chk(oe_n, 32'h0);
    end
    is_tx <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(oe_n, 32'h1);
    is_tx <= 1'b1;
    apb(1'b1, `ITP_ADDR_CTL, ctl(1'b0, 2'b00, 2'b00, 1'b1, 2'b11, 1'b0, 1'b0));
    @(posedge pclk);
    chk(oe_n, 32'h1);
  endtask
  task automatic t_cip();
    apb(1'b1, `ITP_ADDR_HQ1, 32'h00010000);
    cycle();
    chk(np, 2);
    chk({pk[0][31:8], 8'h00}, 32'h00010000);
    chk(pk[1], 32'h02123456);
    apb(1'b1, `ITP_ADDR_CTL, ctl(1'b0, 2'b00, 2'b00, 1'b1, 2'b11, 1'b1, 1'b0));
    cycle();
    chk(pk[1], 32'h0212FFFF);
  endtask
  task automatic t_syt();
    logic [1:0] sd [3] = '{2'b01, 2'b00, 2'b10};
    logic [3:0] dl [3] = '{4'h2, 4'h3, 4'h4};
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `ITP_ADDR_CTL, ctl(1'b0, 2'b00, sd[k], 1'b1, 2'b11, 1'b1, 1'b0));
      frame();
      cycle();
      chk(pk[1], {16'h0212, 4'h5 + dl[k], 12'hABC});
    end
  endtask
  task automatic t_audio();
    apb(1'b1, `ITP_ADDR_CTL, ctl(1'b1, 2'b00, 2'b00, 1'b1, 2'b00, 1'b1, 1'b0));
    frame();
    cycle();
    chk(pk[1], 32'h0212FFFF);
    send_word(32'hA1B2C3D4);
    send_word(32'h5E6F7081);
    cycle();
    chk(np, 3);
    chk(pk[1], 32'h0212AABC);
    chk(pk[2], 32'hA1B2C3D4);
    cycle();
    chk(pk[2], 32'h5E6F7081);
    chk(pk[1], 32'h0212FFFF);
  endtask
  task automatic t_rst();
    int n;
    apb(1'b1, `ITP_ADDR_CTL, ctl(1'b0, 2'b00, 2'b00, 1'b1, 2'b00, 1'b0, 1'b0));
    send_word(32'h13579BDF);
    apb(1'b1, `ITP_ADDR_CTL, ctl(1'b0, 2'b00, 2'b00, 1'b0, 2'b00, 1'b0, 1'b1));
    repeat (20) @(posedge pclk);
    apb(1'b1, `ITP_ADDR_CTL, ctl(1'b0, 2'b00, 2'b00, 1'b1, 2'b00, 1'b0, 1'b0));
    cycle();
    chk(np, 2);
    apb(1'b1, `ITP_ADDR_CTL, ctl(1'b0, 2'b00, 2'b00, 1'b0, 2'b00, 1'b0, 1'b0));
    n = 0;
    @(posedge pclk);
    cs <= 1'b1;
    @(posedge pclk);
    cs <= 1'b0;
    repeat (10) begin
      @(posedge pclk);
      n += (pv !== 1'b0) + (act !== 1'b0);
    end
    chk(n, 0);
  endtask

  task automatic t_sph();
    slow <= 1'b1;
    apb(1'b1, `ITP_ADDR_CTL, 32'h00000000);
    apb(1'b1, `ITP_ADDR_HQ1, 32'h00020400);
    apb(1'b1, `ITP_ADDR_CTL, ctl(1'b0, 2'b00, 2'b00, 1'b1, 2'b00, 1'b0, 1'b0) | 32'h00130000);
    send_word(32'h2468ACE0);
    cycle();
    chk(np, 4);
    chk(pk[2], 32'h000171BC);
    chk(pk[3], 32'h2468ACE0);
    slow <= 1'b0;
  endtask

  task automatic give_verdict();
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_clk();
    t_cip();
    t_syt();
    t_audio();
    t_sph();
    t_rst();
    give_verdict();
  end
  initial begin
    #500us;
    fails++;
    give_verdict();
  end
endmodule // tb_top
